// ===== rtl/fkm_pkg.sv
package fkm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_INDEX    = 8'h04;
    localparam logic [7:0] OFS_BUFFER   = 8'h08;
    localparam logic [7:0] OFS_SECURITY = 8'h0C;
    localparam logic [7:0] OFS_MARGIN   = 8'h10;
    // status register bit positions
    localparam int BIT_DONE    = 7;
    localparam int BIT_ACC_ERR = 5;
    localparam int BIT_PVIOL  = 4;
    localparam int BIT_VERR   = 1;
    localparam int BIT_VUNC   = 0;
    // security register field positions
    localparam int KEY_EN_LSB = 6;
    localparam int SEC_LSB    = 0;
    // margin register field positions
    localparam int PMARG_LSB  = 0;
    localparam int DMARG_LSB  = 4;
    // command codes
    localparam logic [7:0] CMD_KEY_CHECK    = 8'h0C;
    localparam logic [7:0] CMD_USER_MARGIN  = 8'h0D;
    localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
    // buffer index expected at launch, highest buffer index and buffer and key word counts
    localparam logic [2:0] IDX_KEY_LAST  = 3'b100;
    localparam logic [2:0] IDX_MARGIN    = 3'b001;
    localparam logic [2:0] IDX_MAX       = 3'b101;
    localparam int         BUF_WORDS     = 6;
    localparam int         KEY_WORDS     = 4;
    // key enable code that permits the key check
    localparam logic [1:0] KEY_EN_ON     = 2'b10;
    // margin level codes
    localparam logic [15:0] MARG_NORMAL  = 16'h0000;
    localparam logic [15:0] MARG_USER1   = 16'h0001;
    localparam logic [15:0] MARG_USER0   = 16'h0002;
    localparam logic [15:0] MARG_FIELD1  = 16'h0003;
    localparam logic [15:0] MARG_FIELD0  = 16'h0004;
    // global address [17:16] block selects
    localparam logic [1:0] BLK_DATA      = 2'b01;
    localparam logic [1:0] BLK_PROGRAM   = 2'b11;
    // reset values and the unsecured security code
    localparam logic [2:0] MARGIN_RST    = 3'h0;
    localparam logic [2:0] INDEX_RST     = 3'h0;
    localparam logic [1:0] SEC_UNSECURED = 2'b10;
    // sequencer states
    typedef enum logic [1:0] {SQ_IDLE, SQ_CHECK, SQ_KEY, SQ_DONE} fkm_state_t;
endpackage

// ===== rtl/fkm_top.sv
`timescale 1ns/10ps
// Summary of operation
// - key check is code 0x0C; key words sit at buffer indices 1 to 4.
// - key check rejected with access error unless key enable field is 10.
// - supplied keys compared to stored key, key 0 at lowest address first.
// - all keys matching releases the device security state.
// - mismatch keeps security, errors, and locks out key checks until reset.
// - key check with buffer index other than 100 raises access error.
// - command-complete flag sets after key check, matched or not.
// - user margin is code 0x0D; word0 carries block, index 1 the setting.
// - user margin settings: 0 normal, 1 toward erased, 2 toward programmed.
// - data block margin affects data reads; program block margin affects both.
// - margin error on bad index, bad block, bad setting, or wrong mode.
// - valid margin command records level for block, then sets complete flag.
// - field margin is code 0x0E, same layout, special modes only.
// - field margin also accepts 3 toward erased and 4 toward programmed.
// - field margin on program block applies to both blocks, data to data.
// - field margin errors raise only access error, never other status bits.
module fkm_top (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [63:0] BACKDOOR_KEY,
    input  wire logic [1:0]  KEY_ENABLE,
    input  wire logic [1:0]  SEC_STRAP,
    input  wire logic        SPECIAL_MODE,
    output logic             SECURED,
    output logic             CMD_COMPLETE,
    output logic      [2:0]  P_READ_MARGIN,
    output logic      [2:0]  D_READ_MARGIN
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    fkm_pkg::fkm_state_t state_q;
    logic [15:0]         buf_q [0:fkm_pkg::BUF_WORDS-1];
    logic [2:0]          index_q;
    logic                done_q;
    logic                acc_err_q;
    logic                pviol_q;
    logic                verr_q;
    logic                vunc_q;
    logic                lock_q;
    logic                loaded_q;
    logic [1:0]          sec_q;
    logic [1:0]          key_en_q;
    logic                secured_q;
    logic [2:0]          pmarg_q;
    logic [2:0]          dmarg_q;
    logic [1:0]          key_cnt_q;
    logic                key_bad_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic                set_err;
    logic                wr_acc;
    logic                setup;
    logic                mapped;
    logic                launch;
    logic [7:0]          cmd_code;
    logic [1:0]          blk_sel;
    logic [15:0]         setting;
    logic                is_key;
    logic                is_margin;
    logic                is_field;
    logic                margin_ok;
    logic [15:0]         stored_word;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // setting accepted by a user or field margin command
    function automatic logic margin_valid(input logic [15:0] s, input logic field);
        margin_valid = (s == fkm_pkg::MARG_NORMAL) || (s == fkm_pkg::MARG_USER1) ||
                       (s == fkm_pkg::MARG_USER0) ||
                       (field && ((s == fkm_pkg::MARG_FIELD1) ||
                                  (s == fkm_pkg::MARG_FIELD0)));
    endfunction

    // block select names a real block
    function automatic logic block_valid(input logic [1:0] b);
        block_valid = (b == fkm_pkg::BLK_DATA) || (b == fkm_pkg::BLK_PROGRAM);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus decode and command word fields

    assign setup     = PSEL && !PENABLE;
    assign wr_acc    = PSEL && PENABLE && pready_q && PWRITE;
    assign mapped    = (PADDR == fkm_pkg::OFS_STATUS) || (PADDR == fkm_pkg::OFS_INDEX) ||
                       (PADDR == fkm_pkg::OFS_BUFFER) || (PADDR == fkm_pkg::OFS_SECURITY) ||
                       (PADDR == fkm_pkg::OFS_MARGIN);
    // launch only from idle with no pending error flags
    assign launch    = wr_acc && (PADDR == fkm_pkg::OFS_STATUS) && PWDATA[fkm_pkg::BIT_DONE] &&
                       done_q && !acc_err_q && !pviol_q && (state_q == fkm_pkg::SQ_IDLE);
    assign cmd_code  = buf_q[0][15:8];
    assign blk_sel   = buf_q[0][1:0];
    assign setting   = buf_q[1];
    assign is_key    = (cmd_code == fkm_pkg::CMD_KEY_CHECK);
    assign is_margin = (cmd_code == fkm_pkg::CMD_USER_MARGIN);
    assign is_field  = (cmd_code == fkm_pkg::CMD_FIELD_MARGIN);
    assign margin_ok = (index_q == fkm_pkg::IDX_MARGIN) && block_valid(blk_sel) &&
                       margin_valid(setting, is_field) && (is_margin || SPECIAL_MODE);
    // stored key word, key 0 from the lowest security byte address
    assign stored_word = BACKDOOR_KEY[key_cnt_q*16 +: 16];

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: read data and ready registered in setup, one access cycle

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pready_q  <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q  <= 32'h0000_0000;
            if (!PWRITE) begin
                case (PADDR)
                    fkm_pkg::OFS_STATUS: begin
                        prdata_q[fkm_pkg::BIT_DONE]    <= done_q;
                        prdata_q[fkm_pkg::BIT_ACC_ERR] <= acc_err_q;
                        prdata_q[fkm_pkg::BIT_PVIOL]  <= pviol_q;
                        prdata_q[fkm_pkg::BIT_VERR]   <= verr_q;
                        prdata_q[fkm_pkg::BIT_VUNC]   <= vunc_q;
                    end
                    fkm_pkg::OFS_INDEX: begin
                        prdata_q[2:0] <= index_q;
                    end
                    fkm_pkg::OFS_BUFFER: begin
                        if (index_q <= fkm_pkg::IDX_MAX) begin
                            prdata_q[15:0] <= buf_q[index_q];
                        end
                    end
                    fkm_pkg::OFS_SECURITY: begin
                        prdata_q[fkm_pkg::KEY_EN_LSB +: 2] <= key_en_q;
                        prdata_q[fkm_pkg::SEC_LSB +: 2]   <= sec_q;
                    end
                    fkm_pkg::OFS_MARGIN: begin
                        prdata_q[fkm_pkg::PMARG_LSB +: 3] <= pmarg_q;
                        prdata_q[fkm_pkg::DMARG_LSB +: 3] <= dmarg_q;
                    end
                    default: begin
                        prdata_q <= 32'h0000_0000;
                    end
                endcase
            end
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // index and command buffer, writable only while no command runs

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            index_q <= fkm_pkg::INDEX_RST;
            for (int i = 0; i < fkm_pkg::BUF_WORDS; i++) begin
                buf_q[i] <= 16'h0000;
            end
        end else if (wr_acc && done_q) begin
            if (PADDR == fkm_pkg::OFS_INDEX) begin
                index_q <= PWDATA[2:0];
            end
            if ((PADDR == fkm_pkg::OFS_BUFFER) && (index_q <= fkm_pkg::IDX_MAX)) begin
                buf_q[index_q] <= PWDATA[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // security and key enable caught once after reset release

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            loaded_q  <= 1'b0;
            sec_q     <= 2'b00;
            key_en_q  <= 2'b00;
            secured_q <= 1'b1;
        end else if (!loaded_q) begin
            loaded_q  <= 1'b1;
            sec_q     <= SEC_STRAP;
            key_en_q  <= KEY_ENABLE;
            secured_q <= (SEC_STRAP != fkm_pkg::SEC_UNSECURED);
        end else if ((state_q == fkm_pkg::SQ_KEY) && (key_cnt_q == 2'd3) &&
                     !key_bad_q && (buf_q[4] == stored_word)) begin
            sec_q     <= fkm_pkg::SEC_UNSECURED;
            secured_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q   <= fkm_pkg::SQ_IDLE;
            key_cnt_q <= 2'd0;
            key_bad_q <= 1'b0;
        end else begin
            case (state_q)
                fkm_pkg::SQ_IDLE: begin
                    key_cnt_q <= 2'd0;
                    key_bad_q <= 1'b0;
                    if (launch) begin
                        state_q <= fkm_pkg::SQ_CHECK;
                    end
                end
                fkm_pkg::SQ_CHECK: begin
                    if (is_key && (key_en_q == fkm_pkg::KEY_EN_ON) && !lock_q &&
                        (index_q == fkm_pkg::IDX_KEY_LAST)) begin
                        state_q <= fkm_pkg::SQ_KEY;
                    end else begin
                        state_q <= fkm_pkg::SQ_DONE;
                    end
                end
                fkm_pkg::SQ_KEY: begin
                    // one key word per cycle, key 0 first
                    if (buf_q[3'(key_cnt_q) + 3'd1] != stored_word) begin
                        key_bad_q <= 1'b1;
                    end
                    key_cnt_q <= key_cnt_q + 2'd1;
                    if (key_cnt_q == 2'(fkm_pkg::KEY_WORDS - 1)) begin
                        state_q <= fkm_pkg::SQ_DONE;
                    end
                end
                fkm_pkg::SQ_DONE: begin
                    state_q <= fkm_pkg::SQ_IDLE;
                end
                default: begin
                    state_q <= fkm_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error detection and mismatch lockout

    always_comb begin
        set_err = 1'b0;
        if (state_q == fkm_pkg::SQ_CHECK) begin
            if (is_key) begin
                set_err = (key_en_q != fkm_pkg::KEY_EN_ON) || lock_q ||
                          (index_q != fkm_pkg::IDX_KEY_LAST);
            end else if (is_margin || is_field) begin
                set_err = !margin_ok;
            end else begin
                set_err = 1'b1; // unknown command code
            end
        end else if ((state_q == fkm_pkg::SQ_KEY) && (key_cnt_q == 2'd3)) begin
            set_err = key_bad_q || (buf_q[4] != stored_word);
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            lock_q <= 1'b0;
        end else if ((state_q == fkm_pkg::SQ_KEY) && set_err) begin
            lock_q <= 1'b1; // held until reset
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags; hardware set wins over software clear

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            done_q    <= 1'b1;
            acc_err_q <= 1'b0;
            pviol_q   <= 1'b0;
            verr_q    <= 1'b0;
            vunc_q    <= 1'b0;
        end else begin
            if (state_q == fkm_pkg::SQ_DONE) begin
                done_q <= 1'b1;
            end else if (launch) begin
                done_q <= 1'b0;
            end
            if (set_err) begin
                acc_err_q <= 1'b1;
            end else if (wr_acc && (PADDR == fkm_pkg::OFS_STATUS) &&
                         PWDATA[fkm_pkg::BIT_ACC_ERR]) begin
                acc_err_q <= 1'b0;
            end
            if (wr_acc && (PADDR == fkm_pkg::OFS_STATUS) && PWDATA[fkm_pkg::BIT_PVIOL]) begin
                pviol_q <= 1'b0;
            end
            if (launch) begin
                verr_q <= 1'b0; // these commands never set verify status
                vunc_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read margin levels

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pmarg_q <= fkm_pkg::MARGIN_RST;
            dmarg_q <= fkm_pkg::MARGIN_RST;
        end else if ((state_q == fkm_pkg::SQ_CHECK) && (is_margin || is_field) && margin_ok) begin
            dmarg_q <= setting[2:0];
            if (blk_sel == fkm_pkg::BLK_PROGRAM) begin
                pmarg_q <= setting[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign PRDATA        = prdata_q;
    assign PREADY        = pready_q;
    assign PSLVERR       = pslverr_q;
    assign SECURED       = secured_q;
    assign CMD_COMPLETE  = done_q;
    assign P_READ_MARGIN = pmarg_q;
    assign D_READ_MARGIN = dmarg_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    AST_DONE_RETURNS: assert property (@(posedge CLK) disable iff (!RESETN)
        launch |=> !done_q ##[1:7] done_q)
        else $error("complete flag did not return after launch");

    AST_KEY_EN_REJECT: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_q == fkm_pkg::SQ_CHECK) && is_key && (key_en_q != fkm_pkg::KEY_EN_ON)
        |=> acc_err_q && (state_q == fkm_pkg::SQ_DONE))
        else $error("key check ran while key enable disallowed it");

    AST_KEY_INDEX: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_q == fkm_pkg::SQ_CHECK) && is_key && (index_q != fkm_pkg::IDX_KEY_LAST)
        |=> acc_err_q)
        else $error("key check with wrong index not rejected");

    AST_LOCKOUT: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_q == fkm_pkg::SQ_CHECK) && is_key && lock_q
        |=> acc_err_q && $stable(sec_q) ##1 done_q)
        else $error("locked key check was not aborted");

    AST_RELEASE_CAUSE: assert property (@(posedge CLK) disable iff (!RESETN)
        loaded_q && $changed(sec_q) |-> $past(state_q) == fkm_pkg::SQ_KEY && !acc_err_q)
        else $error("security released without a key match");

    AST_MARGIN_REJECT: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_q == fkm_pkg::SQ_CHECK) && (is_margin || is_field) && !margin_ok
        |=> acc_err_q && $stable(pmarg_q) && $stable(dmarg_q))
        else $error("invalid margin command not rejected");

    AST_FIELD_MODE: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_q == fkm_pkg::SQ_CHECK) && is_field && !SPECIAL_MODE |=> acc_err_q)
        else $error("field margin accepted outside special mode");

    AST_NO_OTHER_FLAGS: assert property (@(posedge CLK) disable iff (!RESETN)
        !pviol_q && !verr_q && !vunc_q)
        else $error("status bit other than access error was set");

    AST_PBLOCK_BOTH: assert property (@(posedge CLK) disable iff (!RESETN)
        $changed(pmarg_q) |-> pmarg_q == dmarg_q)
        else $error("program block margin did not reach data reads");

    AST_MARGIN_SET: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_q == fkm_pkg::SQ_CHECK) && (is_margin || is_field) && margin_ok
        |=> dmarg_q == $past(setting[2:0]) && !acc_err_q ##1 done_q)
        else $error("valid margin command did not record its level");

endmodule

// ===== bench/fkm_sw.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// software model: apb master that loads the command buffer and launches commands
// sequences run from bench code, never from the block holding the key
module fkm_sw (
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    input  wire logic        cmd_complete,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    // bus idle at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one transfer; request held until pready is seen high at a falling edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        logic rdy;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // registered answer read mid-cycle, it stands through the closing edge
        do begin
            @(negedge clk);
            rdy = pready;
            r   = prdata;
            e   = pslverr;
            @(posedge clk);
        end while (rdy !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // clear old errors, load word0 and parameters, set launch index, launch
    task automatic cmd(input logic [7:0] code, input logic [1:0] blk,
                       input logic [63:0] wv, input int nw, input logic [2:0] last,
                       output logic [31:0] st);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, fkm_pkg::OFS_STATUS, 32'h0000_0030, r, e);
        xfer(1'b1, fkm_pkg::OFS_INDEX, 32'h0000_0000, r, e);
        xfer(1'b1, fkm_pkg::OFS_BUFFER, {16'h0000, code, 6'h00, blk}, r, e);
        for (int k = 1; k <= nw; k++) begin
            xfer(1'b1, fkm_pkg::OFS_INDEX, 32'(k), r, e);
            xfer(1'b1, fkm_pkg::OFS_BUFFER, {16'h0000, wv[16*(k-1)+:16]}, r, e);
        end
        xfer(1'b1, fkm_pkg::OFS_INDEX, {29'h0, last}, r, e);
        xfer(1'b1, fkm_pkg::OFS_STATUS, 32'h0000_0080, r, e);
        // no register write while the flag is low
        repeat (2) @(posedge clk);
        while (cmd_complete !== 1'b1) begin
            @(posedge clk);
        end
        xfer(1'b0, fkm_pkg::OFS_STATUS, 32'h0000_0000, st, e);
    endtask
endmodule

// ===== bench/tb_fkm_top.sv
`timescale 1ns/10ps
module tb_fkm_top;
    localparam logic [63:0] KEY = 64'h1234_5678_9abc_def0;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic        special, secured, complete, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, st, r;
    logic [1:0]  key_enable_field;
    logic [2:0]  pm, dm;
    int          n_errors, comparisons;

    ////////////////////////////////////////////////////////////////////////////
    // device and software model
    fkm_top i_dut (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BACKDOOR_KEY(KEY), .KEY_ENABLE(key_enable_field), .SEC_STRAP(2'b00),
        .SPECIAL_MODE(special), .SECURED(secured), .CMD_COMPLETE(complete),
        .P_READ_MARGIN(pm), .D_READ_MARGIN(dm)
    );
    fkm_sw i_sw (
        .clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .cmd_complete(complete), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata)
    );

    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and reset helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic rst(input logic [1:0] ke);
        resetn <= 1'b0;
        key_enable_field  <= ke;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // margin command, then status and both margins against expectations
    task automatic mc(input logic f, input logic [1:0] b, input logic [15:0] v,
                      input logic er, input logic [2:0] ep, input logic [2:0] ed,
                      input logic [2:0] ix = fkm_pkg::IDX_MARGIN);
        i_sw.cmd(f ? fkm_pkg::CMD_FIELD_MARGIN : fkm_pkg::CMD_USER_MARGIN, b, {48'h0, v}, 1,
                 ix, st);
        chk(st, {24'h0, 1'b1, 1'b0, er, 5'h00});
        chk({29'h0, pm}, {29'h0, ep});
        chk({29'h0, dm}, {29'h0, ed});
    endtask

    // key check with four words, then status and security state
    task automatic kc(input logic [63:0] w, input logic [2:0] ix, input logic er,
                      input logic se);
        i_sw.cmd(fkm_pkg::CMD_KEY_CHECK, 2'b00, w, 4, ix, st);
        chk(st, {24'h0, 1'b1, 1'b0, er, 5'h00});
        chk({31'h0, secured}, {31'h0, se});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_margin;
        mc(1'b0, fkm_pkg::BLK_PROGRAM, 16'h0001, 1'b0, 3'd1, 3'd1);
        mc(1'b0, fkm_pkg::BLK_DATA, 16'h0002, 1'b0, 3'd1, 3'd2);
        mc(1'b0, fkm_pkg::BLK_PROGRAM, 16'h0003, 1'b1, 3'd1, 3'd2);
        mc(1'b0, fkm_pkg::BLK_PROGRAM, 16'h0000, 1'b1, 3'd1, 3'd2, 3'b010);
        mc(1'b0, 2'b00, 16'h0000, 1'b1, 3'd1, 3'd2);
        mc(1'b1, fkm_pkg::BLK_DATA, 16'h0004, 1'b1, 3'd1, 3'd2);
        special <= 1'b1;
        mc(1'b1, fkm_pkg::BLK_DATA, 16'h0004, 1'b0, 3'd1, 3'd4);
        mc(1'b1, fkm_pkg::BLK_PROGRAM, 16'h0003, 1'b0, 3'd3, 3'd3);
        mc(1'b1, fkm_pkg::BLK_PROGRAM, 16'h0005, 1'b1, 3'd3, 3'd3);
        mc(1'b0, fkm_pkg::BLK_PROGRAM, 16'h0000, 1'b0, 3'd0, 3'd0);
    endtask

    task automatic t_key;
        kc(KEY, 3'b011, 1'b1, 1'b1);
        kc(KEY, 3'b101, 1'b1, 1'b1);
        kc(KEY, fkm_pkg::IDX_KEY_LAST, 1'b0, 1'b0);
        i_sw.xfer(1'b0, fkm_pkg::OFS_SECURITY, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0082);
        rst(fkm_pkg::KEY_EN_ON);
        kc({KEY[15:0], KEY[63:16]}, fkm_pkg::IDX_KEY_LAST, 1'b1, 1'b1);
        kc(KEY, fkm_pkg::IDX_KEY_LAST, 1'b1, 1'b1);
        rst(fkm_pkg::KEY_EN_ON);
        kc(KEY, fkm_pkg::IDX_KEY_LAST, 1'b0, 1'b0);
        rst(2'b01);
        kc(KEY, fkm_pkg::IDX_KEY_LAST, 1'b1, 1'b1);
        rst(2'b11);
        kc(KEY, fkm_pkg::IDX_KEY_LAST, 1'b1, 1'b1);
    endtask

    // unmapped address answers with an error and zero data; unknown code is refused
    task automatic t_bus;
        i_sw.xfer(1'b0, 8'h14, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        i_sw.cmd(8'h0F, 2'b00, 64'h0, 0, 3'b000, st);
        chk(st, 32'h0000_00A0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        resetn      = 1'b0;
        key_enable_field       = 2'b00;
        special     = 1'b0;
        n_errors    = 0;
        comparisons = 0;
        rst(fkm_pkg::KEY_EN_ON);
        t_margin();
        t_key();
        t_bus();
        results();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule
